// >>> inc/dcp_pkg.sv
// package: register map, reset values and timing constants of the dual channel pwm
package dcp_pkg;
  localparam int unsigned DATA_W         = 8;
  // printed offsets 0xfc, 0xfd, 0xfe are not all multiples of four: they are indices
  localparam logic [7:0]  IDX_DUTY_CH0   = 8'hfc;
  localparam logic [7:0]  IDX_DUTY_CH1   = 8'hfd;
  localparam logic [7:0]  IDX_PRESCALE   = 8'hfe;
  localparam logic [9:0]  ADDR_DUTY_CH0  = {IDX_DUTY_CH0, 2'b00};
  localparam logic [9:0]  ADDR_DUTY_CH1  = {IDX_DUTY_CH1, 2'b00};
  localparam logic [9:0]  ADDR_PRESCALE  = {IDX_PRESCALE, 2'b00};
  localparam logic [7:0]  RST_DUTY       = 8'h00;
  localparam logic [7:0]  RST_PRESCALE   = 8'h00;
  localparam logic [7:0]  CNT_LAST       = 8'hfe;
  localparam logic [7:0]  CNT_FIRST      = 8'h00;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam int unsigned CLK_FREQ_HZ    = 10000000;
  typedef logic [DATA_W-1:0] dcp_byte_t;
endpackage

// >>> inc/dcp_tick_if.sv
// interface: tick strobes and shared counter between the timebase and the channels
`timescale 1ns/1ps
interface dcp_tick_if;
  logic               cnt_tick;
  logic [7:0]         cnt_value;
  modport src (output cnt_tick, output cnt_value);
  modport snk (input cnt_tick, input cnt_value);
endinterface

// >>> design/dcp_timebase.sv
// shared timebase: divide-by-two, reloading prescaler and modulo-255 counter
`timescale 1ns/1ps
module dcp_timebase (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [7:0]   prescale_reload,
  dcp_tick_if.src           tb
);
  import dcp_pkg::*;

  logic       half_reg;
  logic [7:0] pre_reg;
  logic [7:0] cnt_reg;
  logic       tick_reg;

  wire pre_done = half_reg && (pre_reg == 8'h00);
  wire cnt_wrap = (cnt_reg == CNT_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_reg <= 1'b0;
      pre_reg  <= 8'h00;
      cnt_reg  <= CNT_FIRST;
      tick_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      tick_reg <= pre_done;
      if (pre_done) begin
        pre_reg <= prescale_reload;
      end else if (half_reg) begin
        pre_reg <= pre_reg - 8'h01;
      end
      if (pre_done) begin
        cnt_reg <= cnt_wrap ? CNT_FIRST : cnt_reg + 8'h01;
      end
    end
  end

  assign tb.cnt_tick  = tick_reg;
  assign tb.cnt_value = cnt_reg;
endmodule

// >>> design/dcp_top.sv
// dual channel pwm: ahb-lite register slave, shared timebase, two active-low outputs
//
// What this block does
// - 8-bit prescaler divides by reload plus one
// - counter advances only on prescaler ticks
// - one prescaler and counter serve both channels
// - counter counts 0 to 254 then wraps
// - output low while duty exceeds counter
// - output high while duty not above counter
// - duty 00 always high, ff always low
// - period is 2 x (reload+1) x 255 clocks
// - duty write takes effect at once, unbuffered
// - prescaler read returns reload, not count
// - output pins serve no alternate function
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module dcp_top (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic                     pwm_channel_output_n0,
  output logic                     pwm_channel_output_n1
);
  import dcp_pkg::*;

  dcp_tick_if tb ();

  dcp_byte_t  pwm_duty_ch0_reg;
  dcp_byte_t  pwm_duty_ch1_reg;
  dcp_byte_t  pwm_prescale_reload_reg;
  logic       wr_pend_reg;
  logic [9:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic       out0_reg;
  logic       out1_reg;

  function automatic logic dcp_low(input logic [7:0] duty, input logic [7:0] cnt);
    dcp_low = duty > cnt;
  endfunction

  // address phase decode
  wire        take      = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire [9:0]  a_word    = haddr[9:0];
  wire        hit_d0    = (a_word == ADDR_DUTY_CH0);
  wire        hit_d1    = (a_word == ADDR_DUTY_CH1);
  wire        hit_pre   = (a_word == ADDR_PRESCALE);
  wire        in_range  = (haddr[31:10] == 22'h000000);
  wire [7:0]  rd_byte   = !in_range ? 8'h00 :
                          hit_d0    ? pwm_duty_ch0_reg :
                          hit_d1    ? pwm_duty_ch1_reg :
                          hit_pre   ? pwm_prescale_reload_reg : 8'h00;
  wire        wr_d0     = wr_pend_reg && (wr_addr_reg == ADDR_DUTY_CH0);
  wire        wr_d1     = wr_pend_reg && (wr_addr_reg == ADDR_DUTY_CH1);
  wire        wr_pre    = wr_pend_reg && (wr_addr_reg == ADDR_PRESCALE);

  // zero wait states; unmapped reads give zero, unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 10'h000;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= take && hwrite && in_range && (hsize == HSIZE_WORD);
      wr_addr_reg <= a_word;
      if (take && !hwrite) begin
        hrdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_duty_ch0_reg        <= RST_DUTY;
      pwm_duty_ch1_reg        <= RST_DUTY;
      pwm_prescale_reload_reg <= RST_PRESCALE;
    end else begin
      if (wr_d0) begin
        pwm_duty_ch0_reg <= hwdata[7:0];
      end
      if (wr_d1) begin
        pwm_duty_ch1_reg <= hwdata[7:0];
      end
      if (wr_pre) begin
        pwm_prescale_reload_reg <= hwdata[7:0];
      end
    end
  end

  dcp_timebase u_timebase (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .prescale_reload (pwm_prescale_reload_reg),
    .tb              (tb.src)
  );

  // compare every cycle, so a new duty shows on the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out0_reg <= 1'b1;
      out1_reg <= 1'b1;
    end else begin
      out0_reg <= ~dcp_low(pwm_duty_ch0_reg, tb.cnt_value);
      out1_reg <= ~dcp_low(pwm_duty_ch1_reg, tb.cnt_value);
    end
  end

  assign hrdata                = hrdata_reg;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  // dedicated push-pull pins, no alternate mux
  assign pwm_channel_output_n0 = out0_reg;
  assign pwm_channel_output_n1 = out1_reg;
endmodule

// >>> test/dcp_chk.sv
// checker: bus answers and output relations of the pwm block
`timescale 1ns/1ps
module dcp_chk
  import dcp_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pwm_channel_output_n0,
  input wire logic        pwm_channel_output_n1
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk  = hsel && hready && htrans == HTRANS_NONSEQ;
  wire wr0 = tk && hwrite && haddr == {22'h0, ADDR_DUTY_CH0};
  wire wr1 = tk && hwrite && haddr == {22'h0, ADDR_DUTY_CH1};
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  // new read data lands at the taking edge, so stability is judged one edge later
  a_rdata_hold: assert property ((tk && !hwrite) ##1 !(tk && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_unmap_zero: assert property (tk && !hwrite && haddr[31:10] != 0 |=> hrdata == 0) else $error("unmapped read"); 
  a_ff_low: assert property (wr0 ##1 hwdata[7:0] == 8'hff |-> ##2 !pwm_channel_output_n0 [*4])
    else $error("ch0 not low");
  a_zero_high: assert property (wr1 ##1 hwdata[7:0] == 8'h00 |-> ##2 pwm_channel_output_n1)
    else $error("ch1 not high");
  a_reset_high: assert property ($rose(hresetn) |-> pwm_channel_output_n0 && pwm_channel_output_n1)
    else $error("outputs low after reset");
  c_write: cover property (wr0);
  c_fall: cover property ($fell(pwm_channel_output_n1));
  c_unmap: cover property (tk && haddr[31:10] != 0);
endmodule

// >>> test/dcp_integ.sv
// far side model: integrator front end timing low phase and period
`timescale 1ns/1ps
module dcp_integ (
  input wire logic hclk,
  input wire logic pwm_n
);
  int   cnt = 0;
  int   low_len = 0;
  int   period = 0;
  logic prev = 1'b1;
  always @(posedge hclk) begin
    prev <= pwm_n;
    cnt  <= cnt + 1;
    if (prev && !pwm_n) begin
      period <= cnt;
      cnt    <= 1;
    end
    if (!prev && pwm_n) low_len <= cnt;
  end
endmodule

// >>> test/dual_channel_pwm_tb.sv
// testbench: dual channel pwm over ahb-lite
`timescale 1ns/1ps
module dual_channel_pwm_tb;
  import dcp_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, o0, o1, bad;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = HSIZE_WORD;
  int          err_count = 0, tests_run = 0;
  dcp_top dut_u(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_channel_output_n0(o0), .pwm_channel_output_n1(o1));
  dcp_integ p0(.hclk(hclk), .pwm_n(o0));
  dcp_integ p1(.hclk(hclk), .pwm_n(o1));
  initial forever #50 hclk = ~hclk;
  task tally_and_finish;
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bounded wait: a stuck hready must not hang the run
  task wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin
        err_count++;
        tally_and_finish;
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    wt;
    htrans <= 2'h0; hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task s_regs;
    xfer(0, ADDR_DUTY_CH0, 0); cmp(q, 0);
    xfer(0, ADDR_DUTY_CH1, 0); cmp(q, 0);
    xfer(1, ADDR_PRESCALE, 32'h5a); xfer(0, ADDR_PRESCALE, 0); cmp(q, 32'h5a);
    xfer(1, 32'h400, 32'h77); xfer(0, 32'h400, 0); cmp(q, 0);
  endtask
  // reload 1: four clocks a step, so period 1020; 254 checks the top count
  task s_period;
    xfer(1, ADDR_PRESCALE, 1); xfer(1, ADDR_DUTY_CH0, 100); xfer(1, ADDR_DUTY_CH1, 254);
    // old reload may still be counting down, and the counter starts mid-period
    repeat (2600) @(posedge hclk);
    cmp(p0.period, 1020);
    cmp(p0.low_len, 400);
    cmp(p1.low_len, 1016);
    cmp(p0.cnt, p1.cnt);
  endtask
  task s_ext;
    xfer(1, ADDR_DUTY_CH0, 32'hff); xfer(1, ADDR_DUTY_CH1, 0);
    bad = 0;
    repeat (3) @(posedge hclk);
    repeat (1100) @(posedge hclk) if (o0 !== 1'b0 || o1 !== 1'b1) bad = 1;
    cmp(bad, 0);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_regs;
    s_period;
    s_ext;
    tally_and_finish;
  end
endmodule
bind dcp_top dcp_chk chk_u(.*);
